// [hdl/bmq_ahb.v]
// AHB-Lite register slave with control, status and interrupt registers
`timescale 1ns/100ps
`default_nettype none
`include "bmq_regs.vh"
module bmq_ahb (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    output reg irq,
    input wire [`BMQ_STAT_W-1:0] stat,
    input wire [`BMQ_NEV-1:0] ev,
    output reg [`BMQ_CTRL_W-1:0] ctrl,
    output reg mrst
);
    reg wr_pend_r;
    reg [7:0] wa_r;
    reg [`BMQ_NEV-1:0] ist_r;
    reg [`BMQ_NEV-1:0] mask_r;
    reg [`BMQ_NEV-1:0] ist_nxt;
    reg [`BMQ_NEV-1:0] mask_nxt;
    reg [`BMQ_NEV-1:0] clr;
    wire aphase;

    // Only whole-word single transfers are expected; hsize is not checked
    assign aphase = hsel && hready && htrans[1];

    always @* begin
        clr = `BMQ_EV_RST;
        mask_nxt = mask_r;
        if (wr_pend_r && wa_r == `BMQ_ADDR_ISTAT) begin
            clr = hwdata[`BMQ_NEV-1:0];
        end
        if (wr_pend_r && wa_r == `BMQ_ADDR_IMASK) begin
            mask_nxt = hwdata[`BMQ_NEV-1:0];
        end
        // A new event beats a clear in the same cycle
        ist_nxt = (ist_r & ~clr) | ev;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            irq <= 1'b0;
            wr_pend_r <= 1'b0;
            wa_r <= 8'h00;
            ist_r <= `BMQ_EV_RST;
            mask_r <= `BMQ_EV_RST;
            ctrl <= `BMQ_CTRL_RST;
            mrst <= 1'b0;
        end else begin
            ist_r <= ist_nxt;
            mask_r <= mask_nxt;
            irq <= |(ist_nxt & mask_nxt);
            mrst <= 1'b0;
            if (wr_pend_r && wa_r == `BMQ_ADDR_CTRL) begin
                ctrl <= hwdata[`BMQ_CTRL_W-1:0];
                mrst <= hwdata[`BMQ_CTRL_MRST];
            end
            wr_pend_r <= aphase && hwrite;
            if (aphase) begin
                wa_r <= haddr[7:0];
            end
            if (aphase && !hwrite) begin
                case (haddr[7:0])
                    `BMQ_ADDR_CTRL: hrdata <= {28'h0000000, ctrl};
                    `BMQ_ADDR_STAT: hrdata <= {26'h0000000, stat};
                    `BMQ_ADDR_ISTAT: hrdata <= {28'h0000000, ist_r};
                    `BMQ_ADDR_IMASK: hrdata <= {28'h0000000, mask_r};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [hdl/bmq_mem.v]
// Simple dual-port queue storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module bmq_mem #(
    parameter DW = 36,
    parameter AW = 14
) (
    input wire clk,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Read before write: a word written at this edge shows one edge later
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// [hdl/bmq_regs.vh]
// Register map, field positions and size constants of the bus-matching queue pair
`ifndef BMQ_REGS_VH
`define BMQ_REGS_VH

// ************************************************************
// Register byte offsets on the bus
// ************************************************************
`define BMQ_ADDR_CTRL 8'h00
`define BMQ_ADDR_STAT 8'h04
`define BMQ_ADDR_ISTAT 8'h08
`define BMQ_ADDR_IMASK 8'h0C

// ************************************************************
// Control register fields
// ************************************************************
`define BMQ_CTRL_W 4
`define BMQ_CTRL_RST 4'h0
`define BMQ_CTRL_BO 0
`define BMQ_CTRL_FT 1
`define BMQ_CTRL_BW 2
`define BMQ_CTRL_CW 3
`define BMQ_CTRL_MRST 4

// ************************************************************
// Status and interrupt fields
// ************************************************************
`define BMQ_STAT_W 6
`define BMQ_NEV 4
`define BMQ_EV_RST 4'h0
`define BMQ_EV_BRDY 0
`define BMQ_EV_ARDY 1
`define BMQ_EV_AOVF 2
`define BMQ_EV_COVF 3

// ************************************************************
// Piece counts: index of the last piece of a 36-bit entry
// ************************************************************
`define BMQ_LAST_WORD 2'h1
`define BMQ_LAST_BYTE 2'h3
`define BMQ_PC_FIRST 2'h0
`define BMQ_PC_STEP 2'h1
`define BMQ_LANE_WORD 18
`define BMQ_LANE_BYTE 9
`define BMQ_BYTE_MASK 36'h0000001FF
`define BMQ_WORD_MASK 36'h00003FFFF

`endif

// [hdl/bmq_top.v]
// Bus-matching queue pair: A-to-B and C-to-A queues with packing and flags
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "bmq_regs.vh"
// Function
// [RL1] Byte order captured at reset; widths static (here bw and cw follow the ctrl register live)
// [RL2] C word mode packs two halves per entry
// [RL3] C byte mode packs four low-lane bytes
// [RL4] B word mode delivers two halves per entry
// [RL5] B byte mode delivers four bytes per entry
// [RL6] Reader ignores B upper lines in byte mode
// [RL7] Fall-through B ready and load within three
// [RL8] Late clock edge may delay B by one
// [RL9] B ready drops only on final piece read
// [RL10] Standard B empty flag rises next cycle
// [RL11] Standard B empty asserts on final piece
// [RL12] Fall-through A ready and load within three
// [RL13] C entry written only on final piece
// [RL14] Standard A empty flag rises next cycle
// [RL15] Late clock edge may delay A by one
// [RL16] B entry removed after final piece read
module bmq_top #(
    parameter AW = 14
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire [31:0] hrdata,
    output wire hresp,
    output wire irq,
    input wire a_wr_en,
    input wire [35:0] a_wr_data,
    input wire a_rd_en,
    output reg [35:0] a_rd_data,
    output reg port_a_empty_flag,
    output reg port_a_output_ready,
    input wire b_rd_en,
    output reg [17:0] b_rd_data,
    output reg port_b_empty_flag,
    output reg port_b_output_ready,
    input wire c_wr_en,
    input wire [17:0] c_wr_data
);
    localparam PW = AW + 1;
    localparam [PW-1:0] P_ONE = 1;
    localparam [PW-1:0] P_ZERO = 0;
    localparam [PW-1:0] P_FULL = {1'b1, {AW{1'b0}}};

    // ************************************************************
    // Piece helpers of the packing and unpacking sides; only the lane order is shared by both
    // ************************************************************
    // Lane 0 is the least significant piece; big order walks down from the top
    function [1:0] bmq_lane;
        input [1:0] idx;
        input [1:0] last;
        input big;
        begin
            bmq_lane = big ? (last - idx) : idx;
        end
    endfunction

    function [17:0] bmq_piece;
        input [35:0] e;
        input [1:0] k;
        input byte_m;
        reg [35:0] s;
        begin
            s = byte_m ? (e >> (`BMQ_LANE_BYTE * k)) : (e >> (`BMQ_LANE_WORD * k[0]));
            // Upper nine lines are left at zero in byte mode
            bmq_piece = byte_m ? {9'h000, s[8:0]} : s[17:0];
        end
    endfunction

    function [35:0] bmq_place;
        input [35:0] acc;
        input [17:0] d;
        input [1:0] k;
        input byte_m;
        reg [35:0] m;
        reg [35:0] v;
        begin
            if (byte_m) begin
                m = `BMQ_BYTE_MASK << (`BMQ_LANE_BYTE * k);
                v = {27'h0000000, d[8:0]} << (`BMQ_LANE_BYTE * k);
            end else begin
                m = `BMQ_WORD_MASK << (`BMQ_LANE_WORD * k[0]);
                v = {18'h00000, d} << (`BMQ_LANE_WORD * k[0]);
            end
            bmq_place = (acc & ~m) | v;
        end
    endfunction

    // ************************************************************
    // Register slave and captured modes
    // ************************************************************
    wire [`BMQ_CTRL_W-1:0] ctrl;
    wire mrst;
    wire [`BMQ_NEV-1:0] ev;
    wire [`BMQ_STAT_W-1:0] stat;
    reg bo_r;
    reg ft_r;
    wire bw;
    wire cw;

    // Widths are live controls; software must not change them while data flows
    assign bw = ctrl[`BMQ_CTRL_BW];
    assign cw = ctrl[`BMQ_CTRL_CW];

    // ************************************************************
    // Queue state
    // ************************************************************
    reg [PW-1:0] ab_wp_r;
    reg [PW-1:0] ab_wd_r;
    reg [PW-1:0] ab_rp_r;
    reg [PW-1:0] ab_rp_nxt;
    reg [PW-1:0] ca_wp_r;
    reg [PW-1:0] ca_wd_r;
    reg [PW-1:0] ca_rp_r;
    reg [PW-1:0] ca_rp_nxt;
    reg [PW-1:0] ca_wp_nxt;
    wire [35:0] ab_q;
    wire [35:0] ca_q;
    wire ab_full;
    wire ca_full;
    wire ab_we;
    wire ab_avail;
    wire ca_avail;

    reg [35:0] b_ent_r;
    reg [35:0] b_ent_nxt;
    reg [17:0] b_dout_nxt;
    reg [1:0] b_pc_r;
    reg [1:0] b_pc_nxt;
    reg b_flag_r;
    reg b_flag_nxt;
    wire [1:0] b_last;
    wire b_cons;
    wire b_fin;

    reg [35:0] a_dout_nxt;
    reg a_flag_r;
    reg a_flag_nxt;
    wire a_cons;

    reg [35:0] c_acc_r;
    reg [35:0] c_acc_nxt;
    reg [35:0] c_merge;
    reg [1:0] c_pc_r;
    reg [1:0] c_pc_nxt;
    reg ca_we;
    reg c_ovf;
    wire [1:0] c_last;

    assign ab_full = (ab_wp_r - ab_rp_r) == P_FULL;
    assign ca_full = (ca_wp_r - ca_rp_r) == P_FULL;
    assign ab_we = a_wr_en && !ab_full;
    // Delayed write pointer: an entry counts only once storage read data can show it
    assign ab_avail = ab_wd_r != ab_rp_r;
    assign ca_avail = ca_wd_r != ca_rp_r;
    assign b_last = bw ? `BMQ_LAST_BYTE : `BMQ_LAST_WORD;
    assign c_last = cw ? `BMQ_LAST_BYTE : `BMQ_LAST_WORD;
    assign b_cons = b_rd_en && b_flag_r;
    assign b_fin = b_cons && (b_pc_r == b_last);
    assign a_cons = a_rd_en && a_flag_r;

    assign ev[`BMQ_EV_BRDY] = b_flag_nxt && !b_flag_r;
    assign ev[`BMQ_EV_ARDY] = a_flag_nxt && !a_flag_r;
    assign ev[`BMQ_EV_AOVF] = a_wr_en && ab_full;
    assign ev[`BMQ_EV_COVF] = c_ovf;
    assign stat = {ca_full, ab_full, a_flag_r, b_flag_r, ft_r, bo_r};

    bmq_ahb u_ahb (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .irq(irq),
        .stat(stat),
        .ev(ev),
        .ctrl(ctrl),
        .mrst(mrst)
    );

    bmq_mem #(.DW(36), .AW(AW)) u_ab_mem (
        .clk(hclk),
        .we(ab_we),
        .waddr(ab_wp_r[AW-1:0]),
        .wdata(a_wr_data),
        .raddr(ab_rp_nxt[AW-1:0]),
        .rdata(ab_q)
    );

    bmq_mem #(.DW(36), .AW(AW)) u_ca_mem (
        .clk(hclk),
        .we(ca_we),
        .waddr(ca_wp_r[AW-1:0]),
        .wdata(c_merge),
        .raddr(ca_rp_nxt[AW-1:0]),
        .rdata(ca_q)
    );

    // ************************************************************
    // Port B unpacking and flag
    // ************************************************************
    always @* begin
        ab_rp_nxt = ab_rp_r;
        b_ent_nxt = b_ent_r;
        b_dout_nxt = b_rd_data;
        b_pc_nxt = b_pc_r;
        b_flag_nxt = b_flag_r;
        if (ft_r) begin
            if (ab_avail && (!b_flag_r || b_fin)) begin
                // Next entry moves into the output register as the last piece goes
                b_ent_nxt = ab_q; // RL16
                b_dout_nxt = bmq_piece(ab_q, bmq_lane(`BMQ_PC_FIRST, b_last, bo_r), bw); // RL7
                b_pc_nxt = `BMQ_PC_FIRST;
                b_flag_nxt = 1'b1; // RL7
                ab_rp_nxt = ab_rp_r + P_ONE;
            end else if (b_fin) begin
                b_flag_nxt = 1'b0; // RL9
            end else if (b_cons) begin
                b_pc_nxt = b_pc_r + `BMQ_PC_STEP; // RL9
                b_dout_nxt = bmq_piece(b_ent_r, bmq_lane(b_pc_nxt, b_last, bo_r), bw); // RL4 RL5
            end
        end else begin
            if (b_cons) begin
                if (b_pc_r == `BMQ_PC_FIRST) begin
                    b_ent_nxt = ab_q;
                    b_dout_nxt = bmq_piece(ab_q, bmq_lane(b_pc_r, b_last, bo_r), bw); // RL4 RL5
                    ab_rp_nxt = ab_rp_r + P_ONE;
                end else begin
                    b_dout_nxt = bmq_piece(b_ent_r, bmq_lane(b_pc_r, b_last, bo_r), bw);
                end
                b_pc_nxt = b_fin ? `BMQ_PC_FIRST : b_pc_r + `BMQ_PC_STEP;
            end
            // Flag stays up while pieces of the current entry remain
            b_flag_nxt = (b_pc_nxt != `BMQ_PC_FIRST) || (ab_wp_r != ab_rp_nxt); // RL10 RL11
        end
    end

    // ************************************************************
    // Port A read side of the C-to-A queue
    // ************************************************************
    always @* begin
        ca_rp_nxt = ca_rp_r;
        a_dout_nxt = a_rd_data;
        a_flag_nxt = a_flag_r;
        if (ft_r) begin
            if (ca_avail && (!a_flag_r || a_cons)) begin
                a_dout_nxt = ca_q; // RL12
                a_flag_nxt = 1'b1; // RL12
                ca_rp_nxt = ca_rp_r + P_ONE;
            end else if (a_cons) begin
                a_flag_nxt = 1'b0;
            end
        end else begin
            if (a_cons) begin
                a_dout_nxt = ca_q;
                ca_rp_nxt = ca_rp_r + P_ONE;
            end
            a_flag_nxt = ca_wp_r != ca_rp_nxt; // RL14
        end
    end

    // ************************************************************
    // Port C packing
    // ************************************************************
    always @* begin
        c_acc_nxt = c_acc_r;
        c_pc_nxt = c_pc_r;
        ca_wp_nxt = ca_wp_r;
        ca_we = 1'b0;
        c_ovf = 1'b0;
        c_merge = bmq_place(c_acc_r, c_wr_data, bmq_lane(c_pc_r, c_last, bo_r), cw); // RL2 RL3
        if (c_wr_en) begin
            if (c_pc_r == c_last) begin
                c_pc_nxt = `BMQ_PC_FIRST;
                // A full queue drops the whole entry and flags the loss
                if (ca_full) begin
                    c_ovf = 1'b1;
                end else begin
                    ca_we = 1'b1; // RL13
                    ca_wp_nxt = ca_wp_r + P_ONE;
                end
            end else begin
                c_acc_nxt = c_merge;
                c_pc_nxt = c_pc_r + `BMQ_PC_STEP;
            end
        end
    end

    // ************************************************************
    // State registers
    // ************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bo_r <= 1'b0;
            ft_r <= 1'b0;
            ab_wp_r <= P_ZERO;
            ab_wd_r <= P_ZERO;
            ab_rp_r <= P_ZERO;
            ca_wp_r <= P_ZERO;
            ca_wd_r <= P_ZERO;
            ca_rp_r <= P_ZERO;
            b_ent_r <= 36'h000000000;
            b_pc_r <= `BMQ_PC_FIRST;
            b_flag_r <= 1'b0;
            b_rd_data <= 18'h00000;
            port_b_empty_flag <= 1'b0;
            port_b_output_ready <= 1'b0;
            a_flag_r <= 1'b0;
            a_rd_data <= 36'h000000000;
            port_a_empty_flag <= 1'b0;
            port_a_output_ready <= 1'b0;
            c_acc_r <= 36'h000000000;
            c_pc_r <= `BMQ_PC_FIRST;
        end else if (mrst) begin
            // Soft master reset empties both queues and latches byte order and fall-through mode
            bo_r <= ctrl[`BMQ_CTRL_BO]; // RL1
            ft_r <= ctrl[`BMQ_CTRL_FT];
            ab_wp_r <= P_ZERO;
            ab_wd_r <= P_ZERO;
            ab_rp_r <= P_ZERO;
            ca_wp_r <= P_ZERO;
            ca_wd_r <= P_ZERO;
            ca_rp_r <= P_ZERO;
            b_pc_r <= `BMQ_PC_FIRST;
            b_flag_r <= 1'b0;
            port_b_empty_flag <= 1'b0;
            port_b_output_ready <= 1'b0;
            a_flag_r <= 1'b0;
            port_a_empty_flag <= 1'b0;
            port_a_output_ready <= 1'b0;
            c_pc_r <= `BMQ_PC_FIRST;
        end else begin
            if (ab_we) begin
                ab_wp_r <= ab_wp_r + P_ONE;
            end
            // Single clock: the cross-edge delay never arises, flags take the early slot
            ab_wd_r <= ab_wp_r; // RL8
            ab_rp_r <= ab_rp_nxt;
            ca_wp_r <= ca_wp_nxt;
            ca_wd_r <= ca_wp_r; // RL15
            ca_rp_r <= ca_rp_nxt;
            b_ent_r <= b_ent_nxt;
            b_pc_r <= b_pc_nxt;
            b_flag_r <= b_flag_nxt;
            b_rd_data <= b_dout_nxt;
            port_b_empty_flag <= b_flag_nxt && !ft_r;
            port_b_output_ready <= b_flag_nxt && ft_r;
            a_flag_r <= a_flag_nxt;
            a_rd_data <= a_dout_nxt;
            port_a_empty_flag <= a_flag_nxt && !ft_r;
            port_a_output_ready <= a_flag_nxt && ft_r;
            c_acc_r <= c_acc_nxt;
            c_pc_r <= c_pc_nxt;
        end
    end
endmodule
`default_nettype wire

// [verif/bmq_b_reader.sv]
// Port B reader model that drains the A-to-B queue piece by piece
`timescale 1ns/100ps
`default_nettype none
module bmq_b_reader (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic stall,
    input wire logic ft,
    input wire logic byte_m,
    input wire logic rdy,
    input wire logic emp,
    input wire logic [17:0] din,
    output logic rd_en,
    output logic pc_valid,
    output logic [17:0] pc_data
);
    logic pend;
    logic flag;
    logic took;
    assign flag = ft ? rdy : emp;
    // Fall-through shows the piece before the read, standard one edge after it
    assign took = (ft && rd_en && flag) || pend;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_en <= 1'b0;
            pend <= 1'b0;
            pc_valid <= 1'b0;
            pc_data <= 18'h00000;
        end else begin
            rd_en <= go && !stall && flag;
            pend <= !ft && rd_en && flag;
            pc_valid <= took;
            // Upper lines carry nothing in byte mode
            if (took) pc_data <= byte_m ? {9'h000, din[8:0]} : din;
        end
    end
endmodule
`default_nettype wire

// [verif/bmq_chk_assertions.sv]
// Port-level timing checks of the bus-matching queue pair
`timescale 1ns/100ps
`default_nettype none
module bmq_chk (
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire hresp,
    input wire a_wr_en,
    input wire a_rd_en,
    input wire b_rd_en,
    input wire c_wr_en,
    input wire [17:0] b_rd_data,
    input wire port_a_empty_flag,
    input wire port_a_output_ready,
    input wire port_b_empty_flag,
    input wire port_b_output_ready
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ********
    // Sequences
    // ********
    sequence s_b_idle;
        !port_b_empty_flag && !port_b_output_ready;
    endsequence
    sequence s_b_up;
        port_b_empty_flag || port_b_output_ready;
    endsequence
    chk_bus_zero_wait: assert property (hreadyout && !hresp)
        else $error("Bus slave stalled or answered with an error");
    chk_b_fill_flag: assert property (a_wr_en ##0 s_b_idle |-> ##[2:3] s_b_up)
        else $error("B flag missing after write into empty queue");
    chk_b_ready_rise: assert property ($rose(port_b_output_ready) |-> $past(a_wr_en, 3))
        else $error("B output ready rose without a write three edges before");
    chk_b_empty_rise: assert property ($rose(port_b_empty_flag) |-> $past(a_wr_en, 2))
        else $error("B empty flag rose without a write two edges before");
    chk_a_ready_rise: assert property ($rose(port_a_output_ready) |-> $past(c_wr_en, 3))
        else $error("A output ready rose without a final C write");
    chk_a_empty_rise: assert property ($rose(port_a_empty_flag) |-> $past(c_wr_en, 2))
        else $error("A empty flag rose without a final C write");
    chk_b_flag_drop: assert property (s_b_idle ##0
        $past(port_b_empty_flag || port_b_output_ready) |-> $past(b_rd_en))
        else $error("B flag dropped without a read");
    chk_a_flag_drop: assert property ($fell(port_a_empty_flag || port_a_output_ready)
        |-> $past(a_rd_en))
        else $error("A flag dropped without a read");
    chk_b_data_std: assert property ($changed(b_rd_data) && $past(port_b_empty_flag)
        |-> $past(b_rd_en))
        else $error("B data changed without a read");
    chk_b_data_ft: assert property ($changed(b_rd_data) && $past(port_b_output_ready)
        |-> $past(b_rd_en))
        else $error("B shown data changed without a read");
endmodule
bind bmq_top bmq_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .a_wr_en(a_wr_en), .a_rd_en(a_rd_en), .b_rd_en(b_rd_en),
    .c_wr_en(c_wr_en), .b_rd_data(b_rd_data), .port_a_empty_flag(port_a_empty_flag),
    .port_a_output_ready(port_a_output_ready), .port_b_empty_flag(port_b_empty_flag),
    .port_b_output_ready(port_b_output_ready));
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench of the bus-matching queue pair
`timescale 1ns/100ps
`default_nettype none
`include "bmq_regs.vh"
module tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, seed = 46, q;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic a_wr_en = 0, a_rd_en = 0, c_wr_en = 0, go = 0, stall = 0;
    logic bo = 0, ft = 0, bw = 0, cw = 0;
    logic [35:0] a_wr_data = 0, e;
    logic [17:0] c_wr_data = 0;
    wire hready, hresp, irq, b_rd_en, pc_valid, a_emp, a_rdy, b_emp, b_rdy;
    wire [31:0] hrdata;
    wire [35:0] a_rd_data;
    wire [17:0] b_rd_data, pc_data;
    logic [17:0] exp_b[$];
    int err_total = 0, n_tests = 0;
    always #5 hclk = ~hclk;
    bmq_top #(.AW(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .irq(irq), .a_wr_en(a_wr_en),
        .a_wr_data(a_wr_data), .a_rd_en(a_rd_en), .a_rd_data(a_rd_data),
        .port_a_empty_flag(a_emp), .port_a_output_ready(a_rdy), .b_rd_en(b_rd_en),
        .b_rd_data(b_rd_data), .port_b_empty_flag(b_emp), .port_b_output_ready(b_rdy),
        .c_wr_en(c_wr_en), .c_wr_data(c_wr_data));
    bmq_b_reader u_rd (.clk(hclk), .rst_n(hresetn), .go(go), .stall(stall), .ft(ft),
        .byte_m(bw), .rdy(b_rdy), .emp(b_emp), .din(b_rd_data), .rd_en(b_rd_en),
        .pc_valid(pc_valid), .pc_data(pc_data));
    // ********
    // Helpers
    // ********
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [35:0] rnd36();
        return {rnd(), 4'h0} ^ {4'h0, rnd()};
    endfunction
    // Piece k of an entry in transfer order; the same order serves ports B and C
    function automatic logic [17:0] piece(input logic [35:0] v, input int k, input logic byt,
        input logic big);
        int j;
        j = big ? k : (byt ? 3 : 1) - k;
        if (byt) return {9'h000, v[35 - 9 * j -: 9]};
        return j == 0 ? v[35:18] : v[17:0];
    endfunction
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
        hsel <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h00000000);
        chk(q, exp);
    endtask
    task automatic a_put(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            e = (i == 1) ? 36'h800000001 : rnd36();
            a_wr_en <= 1'b1;
            a_wr_data <= e;
            for (int k = 0; k < (bw ? 4 : 2); k++) exp_b.push_back(piece(e, k, bw, bo));
        end
        @(posedge hclk);
        a_wr_en <= 1'b0;
    endtask
    task automatic c_put(input int k0, input int k1);
        for (int k = k0; k < k1; k++) begin
            @(posedge hclk);
            c_wr_en <= 1'b1;
            c_wr_data <= piece(e, k, cw, bo);
        end
        @(posedge hclk);
        c_wr_en <= 1'b0;
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        stall <= rnd() > 32'hA0000000;
        if (pc_valid === 1'b1) begin
            if (exp_b.size() > 0) chk(pc_data, exp_b.pop_front());
            else chk(1'b1, 1'b0);
        end
    end
    initial begin
        #500000;
        err_total++;
        finish_test();
    end
    // ********
    // Main sequence
    // ********
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int m = 0; m < 16; m++) begin
            {cw, bw, ft, bo} = m[3:0];
            ahb(1'b1, `BMQ_ADDR_CTRL, {27'h0, 1'b1, cw, bw, ft, bo});
            // Flipped order and mode without reset must not take effect
            ahb(1'b1, `BMQ_ADDR_CTRL, {28'h0, cw, bw, ~ft, ~bo});
            rd_chk(`BMQ_ADDR_STAT, {30'h0, ft, bo});
            rd_chk(`BMQ_ADDR_CTRL, {28'h0, cw, bw, ~ft, ~bo});
            a_put(1);
            @(posedge hclk);
            #1 chk(b_emp | b_rdy, !ft);
            @(posedge hclk);
            #1 chk({b_emp, b_rdy}, {!ft, ft});
            go <= 1'b1;
            a_put(4);
            for (int t = 0; t < 400 && exp_b.size() > 0; t++) @(posedge hclk);
            repeat (3) @(posedge hclk);
            #1 chk(36'(exp_b.size()), 36'h0);
            chk(b_emp | b_rdy, 1'b0);
            go <= 1'b0;
            e = rnd36();
            c_put(0, cw ? 3 : 1);
            repeat (4) @(posedge hclk);
            #1 chk(a_emp | a_rdy, 1'b0);
            c_put(cw ? 3 : 1, cw ? 4 : 2);
            @(posedge hclk);
            #1 chk(a_emp | a_rdy, !ft);
            @(posedge hclk);
            #1 chk({a_emp, a_rdy}, {!ft, ft});
            if (ft) chk(a_rd_data, e);
            @(posedge hclk);
            a_rd_en <= 1'b1;
            @(posedge hclk);
            a_rd_en <= 1'b0;
            #1 chk(a_emp | a_rdy, 1'b0);
            if (!ft) chk(a_rd_data, e);
        end
        ahb(1'b1, `BMQ_ADDR_ISTAT, 32'h0000000F);
        ahb(1'b1, `BMQ_ADDR_IMASK, 32'h00000000);
        rd_chk(`BMQ_ADDR_ISTAT, 32'h00000000);
        go <= 1'b1;
        a_put(1);
        repeat (12) @(posedge hclk);
        #1 chk(irq, 1'b0);
        rd_chk(`BMQ_ADDR_ISTAT, 32'h00000001);
        ahb(1'b1, `BMQ_ADDR_IMASK, 32'h00000001);
        repeat (2) @(posedge hclk);
        #1 chk(irq, 1'b1);
        ahb(1'b1, `BMQ_ADDR_ISTAT, 32'h00000001);
        repeat (2) @(posedge hclk);
        #1 chk(irq, 1'b0);
        rd_chk(`BMQ_ADDR_ISTAT, 32'h00000000);
        chk(36'(exp_b.size()), 36'h0);
        // Reader stopped: storage fills behind the output register, the last write drops
        go <= 1'b0;
        a_put(18);
        rd_chk(`BMQ_ADDR_STAT, 32'h00000017);
        rd_chk(`BMQ_ADDR_ISTAT, 32'h00000005);
        rd_chk(8'h10, 32'h00000000);
        finish_test();
    end
endmodule
`default_nettype wire
